// ===== rtl/dse_pkg.sv
// Purpose: shared constants and types for the device status and event register group
// Assumes: one 125 MHz clock, synchronous active high reset
// Notes: register indices are byte address divided by four
package dse_pkg;
  // data, address, index and event widths
  localparam int OCTET_W = 8;
  localparam int WB_DATA_W = 32;
  localparam int WB_ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam int EVT_W = 3;
  // register indices as printed
  localparam logic [IDX_W-1:0] IDX_SPARE_RW = 8'h28;
  localparam logic [IDX_W-1:0] IDX_SPARE_RO = 8'h29;
  localparam logic [IDX_W-1:0] IDX_WDG_CODE = 8'h2a;
  localparam logic [IDX_W-1:0] IDX_DEF_COND = 8'h2b;
  localparam logic [IDX_W-1:0] IDX_COND = 8'h2c;
  localparam logic [IDX_W-1:0] IDX_EV_CLASS = 8'h2d;
  localparam logic [IDX_W-1:0] IDX_EV_HIGH = 8'h2e;
  // control, interrupt status and mask
  localparam logic [IDX_W-1:0] IDX_EV_CTRL = 8'h40;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h41;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h42;
  // control register bit positions
  localparam int CTRL_PENDING_BIT = 0;
  localparam int CTRL_WDG_EN_BIT = 1;
  // interrupt event bit positions
  localparam int EVT_WDG_BIT = 0;
  localparam int EVT_MCLR_BIT = 1;
  localparam int EVT_MREAD_BIT = 2;
  // reset values
  localparam logic [OCTET_W-1:0] OCTET_RST = 8'h00;
  localparam logic [OCTET_W-1:0] WDG_CODE_RST = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
  // event memory address of the status octet
  localparam logic [OCTET_W-1:0] EVMEM_STATUS_ADDR = 8'h00;
  // unmapped reads answer this
  localparam logic [OCTET_W-1:0] UNMAPPED_DATA = 8'h00;
endpackage : dse_pkg

// ===== rtl/reg_access_if.sv
// Purpose: carries decoded register accesses from the bus slave to the register bank
// Assumes: single clock domain
// Notes: wr is a one cycle strobe at the acknowledging edge
`timescale 1ns/1ps
interface reg_access_if;
  logic wr; // commit a write this edge
  logic [dse_pkg::IDX_W-1:0] idx; // register index
  logic [dse_pkg::OCTET_W-1:0] wdata; // low octet of write data
  logic [dse_pkg::OCTET_W-1:0] rdata; // read mux output
  logic hit; // index is mapped
  modport slave (output wr, output idx, output wdata, input rdata, input hit);
  modport bank (input wr, input idx, input wdata, output rdata, output hit);
endinterface : reg_access_if

// ===== rtl/wb_octet_slave.sv
// Purpose: classic wishbone slave that turns cycles into octet register accesses
// Assumes: master holds its request until it sees ack
// Notes: ack one cycle after request; write commits at the ack edge
`timescale 1ns/1ps
module wb_octet_slave #(
  parameter int ADDR_W = dse_pkg::WB_ADDR_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [dse_pkg::WB_DATA_W-1:0] dat_i,
  output logic [dse_pkg::WB_DATA_W-1:0] dat_o,
  output logic ack_o,
  // register side
  reg_access_if.slave rif
);
  // index must fit the decoded address bits
  if (ADDR_W - 2 > dse_pkg::IDX_W || ADDR_W < 9) begin : g_chk
    $error("wb_octet_slave: ADDR_W out of range");
  end

  typedef struct packed {
    logic ack; // answer strobe
    logic [dse_pkg::WB_DATA_W-1:0] rdat; // captured read data
  } slv_state_t;

  slv_state_t s_reg;
  slv_state_t s_next;
  logic req; // new request not yet answered

  assign req = cyc_i & stb_i & ~s_reg.ack;
  assign rif.idx = dse_pkg::IDX_W'(adr_i[ADDR_W-1:2]);
  assign rif.wdata = dat_i[dse_pkg::OCTET_W-1:0];
  // only lane 0 carries the octet; other lanes are dropped
  assign rif.wr = cyc_i & stb_i & we_i & s_reg.ack & sel_i[0];
  assign ack_o = s_reg.ack;
  assign dat_o = s_reg.rdat;

  // next state: ack for one cycle, read data captured with it
  always_comb begin
    s_next = s_reg;
    s_next.ack = req;
    if (req) begin
      // unmapped index answers zero, never stalls the bus
      s_next.rdat = {{(dse_pkg::WB_DATA_W-dse_pkg::OCTET_W){1'b0}},
                     (rif.hit ? rif.rdata : dse_pkg::UNMAPPED_DATA)};
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : wb_octet_slave

// ===== rtl/evt_irq.sv
// Purpose: sticky event status, mask and one level interrupt
// Assumes: events are one cycle strobes on the same clock
// Notes: write one to clear; a set in the clearing cycle wins
`timescale 1ns/1ps
module evt_irq #(
  parameter int N = dse_pkg::EVT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // events and software access
  input wire logic [N-1:0] evt_i,
  input wire logic stat_wr_i,
  input wire logic mask_wr_i,
  input wire logic [N-1:0] wdata_i,
  // state out
  output logic [N-1:0] stat_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);
  if (N < 1 || N > dse_pkg::OCTET_W) begin : g_chk
    $error("evt_irq: N out of range");
  end

  typedef struct packed {
    logic [N-1:0] stat; // sticky event bits
    logic [N-1:0] mask; // one enables the bit onto irq
  } irq_state_t;

  irq_state_t s_reg;
  irq_state_t s_next;

  // clear first, then set so a new event is never lost
  always_comb begin
    s_next = s_reg;
    if (stat_wr_i) begin
      s_next.stat = s_reg.stat & ~wdata_i;
    end
    s_next.stat = s_next.stat | evt_i;
    if (mask_wr_i) begin
      s_next.mask = wdata_i;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stat_o = s_reg.stat;
  assign mask_o = s_reg.mask;
  assign irq_o = |(s_reg.stat & s_reg.mask);
endmodule : evt_irq

// ===== rtl/device_status_event_regs.sv
// Purpose: device status octet, default, watchdog code and event octets
// Assumes: link side logic runs on clk_i, strobes last one cycle
// Notes: host side is classic wishbone, octets in the low byte lane
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module device_status_event_regs #(
  parameter int ADDR_W = dse_pkg::WB_ADDR_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [dse_pkg::WB_DATA_W-1:0] dat_i,
  output logic [dse_pkg::WB_DATA_W-1:0] dat_o,
  output logic ack_o,
  // link master event memory read
  input wire logic evmem_rd_i,
  input wire logic [dse_pkg::OCTET_W-1:0] evmem_addr_i,
  output logic [dse_pkg::OCTET_W-1:0] evmem_data_o,
  output logic evmem_valid_o,
  // link master write to the status octet
  input wire logic master_status_wr_i,
  input wire logic [dse_pkg::OCTET_W-1:0] master_status_data_i,
  // watchdog
  input wire logic wdg_expire_i,
  // event reporting
  output logic event_pending_flag_o,
  output logic [dse_pkg::OCTET_W-1:0] event_class_octet_o,
  output logic [dse_pkg::OCTET_W-1:0] event_id_high_o,
  // interrupt
  output logic irq_o
);
  typedef struct packed {
    logic [dse_pkg::OCTET_W-1:0] page1_spare_rw; // plain storage
    logic [dse_pkg::OCTET_W-1:0] watchdog_code_value; // replacement status
    logic [dse_pkg::OCTET_W-1:0] default_device_condition; // answer when idle
    logic [dse_pkg::OCTET_W-1:0] device_condition_value; // live status
    logic [dse_pkg::OCTET_W-1:0] event_class_octet; // qualifier
    logic [dse_pkg::OCTET_W-1:0] event_id_high; // code octet 1
    logic event_pending_flag; // event waiting for the master
    logic watchdog_event_enable; // let expiry replace status
    logic [dse_pkg::OCTET_W-1:0] evmem_data; // link answer octet
    logic evmem_valid; // link answer strobe
  } bank_state_t;

  bank_state_t s_reg;
  bank_state_t s_next;
  reg_access_if rif ();
  logic [dse_pkg::EVT_W-1:0] evt; // interrupt events
  logic [dse_pkg::EVT_W-1:0] irq_stat; // sticky bits
  logic [dse_pkg::EVT_W-1:0] irq_mask; // enables
  logic wdg_fire; // expiry that acts
  logic status_rd; // master reading address 0x00

  // true for every index this bank answers
  function automatic logic is_mapped(input logic [dse_pkg::IDX_W-1:0] idx);
    is_mapped = (idx >= dse_pkg::IDX_SPARE_RW && idx <= dse_pkg::IDX_EV_HIGH) ||
                (idx >= dse_pkg::IDX_EV_CTRL && idx <= dse_pkg::IDX_IRQ_MASK);
  endfunction : is_mapped

  // host write to a given index this cycle
  function automatic logic host_wr(input logic wr, input logic [dse_pkg::IDX_W-1:0] idx,
                                   input logic [dse_pkg::IDX_W-1:0] target);
    host_wr = wr && (idx == target);
  endfunction : host_wr

  // which octet answers event memory address 0x00
  function automatic logic [dse_pkg::OCTET_W-1:0] status_answer(input logic pending,
      input logic [dse_pkg::OCTET_W-1:0] live, input logic [dse_pkg::OCTET_W-1:0] dflt);
    status_answer = pending ? live : dflt;
  endfunction : status_answer

  // bus front end
  wb_octet_slave #(.ADDR_W(ADDR_W)) u_slave (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .rif(rif)
  );

  // interrupt status and mask
  evt_irq #(.N(dse_pkg::EVT_W)) u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .evt_i(evt),
    .stat_wr_i(host_wr(rif.wr, rif.idx, dse_pkg::IDX_IRQ_STAT)),
    .mask_wr_i(host_wr(rif.wr, rif.idx, dse_pkg::IDX_IRQ_MASK)),
    .wdata_i(rif.wdata[dse_pkg::EVT_W-1:0]),
    .stat_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // expiry only acts with the enable set
  assign wdg_fire = wdg_expire_i & s_reg.watchdog_event_enable;
  assign status_rd = evmem_rd_i && (evmem_addr_i == dse_pkg::EVMEM_STATUS_ADDR);

  // events feeding the sticky status
  always_comb begin
    evt = '0;
    evt[dse_pkg::EVT_WDG_BIT] = wdg_fire;
    evt[dse_pkg::EVT_MCLR_BIT] = master_status_wr_i;
    evt[dse_pkg::EVT_MREAD_BIT] = status_rd;
  end

  // host read mux
  assign rif.hit = is_mapped(rif.idx);
  always_comb begin
    rif.rdata = dse_pkg::UNMAPPED_DATA;
    unique case (rif.idx)
      dse_pkg::IDX_SPARE_RW: rif.rdata = s_reg.page1_spare_rw;
      dse_pkg::IDX_SPARE_RO: rif.rdata = dse_pkg::OCTET_RST;
      dse_pkg::IDX_WDG_CODE: rif.rdata = s_reg.watchdog_code_value;
      dse_pkg::IDX_DEF_COND: rif.rdata = s_reg.default_device_condition;
      dse_pkg::IDX_COND: rif.rdata = s_reg.device_condition_value;
      dse_pkg::IDX_EV_CLASS: rif.rdata = s_reg.event_class_octet;
      dse_pkg::IDX_EV_HIGH: rif.rdata = s_reg.event_id_high;
      dse_pkg::IDX_EV_CTRL: begin
        rif.rdata[dse_pkg::CTRL_PENDING_BIT] = s_reg.event_pending_flag;
        rif.rdata[dse_pkg::CTRL_WDG_EN_BIT] = s_reg.watchdog_event_enable;
      end
      dse_pkg::IDX_IRQ_STAT: rif.rdata[dse_pkg::EVT_W-1:0] = irq_stat;
      dse_pkg::IDX_IRQ_MASK: rif.rdata[dse_pkg::EVT_W-1:0] = irq_mask;
      default: rif.rdata = dse_pkg::UNMAPPED_DATA; // unmapped index
    endcase
  end

  // next state of the bank
  always_comb begin
    s_next = s_reg;
    s_next.evmem_valid = 1'b0;
    // host writes; the read-only spare has no write path
    if (host_wr(rif.wr, rif.idx, dse_pkg::IDX_SPARE_RW)) begin
      s_next.page1_spare_rw = rif.wdata;
    end
    if (host_wr(rif.wr, rif.idx, dse_pkg::IDX_WDG_CODE)) begin
      s_next.watchdog_code_value = rif.wdata;
    end
    if (host_wr(rif.wr, rif.idx, dse_pkg::IDX_DEF_COND)) begin
      s_next.default_device_condition = rif.wdata;
    end
    if (host_wr(rif.wr, rif.idx, dse_pkg::IDX_COND)) begin
      s_next.device_condition_value = rif.wdata;
    end
    if (host_wr(rif.wr, rif.idx, dse_pkg::IDX_EV_CLASS)) begin
      s_next.event_class_octet = rif.wdata;
    end
    if (host_wr(rif.wr, rif.idx, dse_pkg::IDX_EV_HIGH)) begin
      s_next.event_id_high = rif.wdata;
    end
    if (host_wr(rif.wr, rif.idx, dse_pkg::IDX_EV_CTRL)) begin
      s_next.event_pending_flag = rif.wdata[dse_pkg::CTRL_PENDING_BIT];
      s_next.watchdog_event_enable = rif.wdata[dse_pkg::CTRL_WDG_EN_BIT];
    end
    // master write beats host write: the link owns the octet
    if (master_status_wr_i) begin
      s_next.device_condition_value = master_status_data_i;
      s_next.event_pending_flag = 1'b0;
    end
    // expiry comes last so the set wins over any clear
    if (wdg_fire) begin
      s_next.device_condition_value = s_reg.watchdog_code_value;
      s_next.event_pending_flag = 1'b1;
    end
    // link answer: one cycle after the request
    if (evmem_rd_i) begin
      s_next.evmem_valid = 1'b1;
      s_next.evmem_data = status_rd ? status_answer(s_reg.event_pending_flag,
          s_reg.device_condition_value, s_reg.default_device_condition) : dse_pkg::UNMAPPED_DATA;
    end
  end

  // state register; every field clears to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.watchdog_code_value <= dse_pkg::WDG_CODE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // link side outputs straight from flops
  assign evmem_data_o = s_reg.evmem_data;
  assign evmem_valid_o = s_reg.evmem_valid;
  assign event_pending_flag_o = s_reg.event_pending_flag;
  assign event_class_octet_o = s_reg.event_class_octet;
  assign event_id_high_o = s_reg.event_id_high;
endmodule : device_status_event_regs

// ===== test/status_event_monitor.sv
// Purpose: port level checks on the status and event register group
// Assumes: one clock, sync reset high, ack one cycle after a request
// Notes: bound to the top module, sees its ports only
`timescale 1ns/1ps
module status_event_monitor #(
  parameter int ADDR_W = dse_pkg::WB_ADDR_W
) (
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [dse_pkg::WB_DATA_W-1:0] dat_i,
  input wire logic [dse_pkg::WB_DATA_W-1:0] dat_o,
  input wire logic ack_o,
  // link side
  input wire logic evmem_rd_i,
  input wire logic [dse_pkg::OCTET_W-1:0] evmem_addr_i,
  input wire logic [dse_pkg::OCTET_W-1:0] evmem_data_o,
  input wire logic evmem_valid_o,
  input wire logic master_status_wr_i,
  input wire logic wdg_expire_i,
  input wire logic event_pending_flag_o,
  input wire logic [dse_pkg::OCTET_W-1:0] event_class_octet_o,
  input wire logic [dse_pkg::OCTET_W-1:0] event_id_high_o
);
  // host write committing at this edge
  logic hw;
  logic [7:0] idx;
  assign hw = cyc_i & stb_i & we_i & ack_o & sel_i[0];
  assign idx = adr_i[9:2];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000) else $error("upper lanes set");
  a_evm_answer: assert property (evmem_rd_i |=> evmem_valid_o) else $error("no event answer");
  a_evm_cause: assert property (evmem_valid_o |-> $past(evmem_rd_i)) else $error("stray answer");
  a_evm_other: assert property (evmem_rd_i && evmem_addr_i != 8'h00 |=> evmem_data_o == 8'h00)
    else $error("other address not zero");
  a_flag_clear: assert property (master_status_wr_i && !wdg_expire_i |=> !event_pending_flag_o)
    else $error("flag not cleared");
  a_flag_cause: assert property ($rose(event_pending_flag_o) |->
    $past(wdg_expire_i) || $past(hw && idx == dse_pkg::IDX_EV_CTRL)) else $error("flag rose alone");
  a_class_load: assert property (hw && idx == dse_pkg::IDX_EV_CLASS |=>
    event_class_octet_o == $past(dat_i[7:0])) else $error("qualifier not loaded");
  a_high_load: assert property (hw && idx == dse_pkg::IDX_EV_HIGH |=>
    event_id_high_o == $past(dat_i[7:0])) else $error("code high not loaded");
  // main scenarios
  c_expire: cover property (wdg_expire_i ##1 event_pending_flag_o);
  c_live_read: cover property (evmem_rd_i && evmem_addr_i == 8'h00 && event_pending_flag_o);
  c_master_wr: cover property (master_status_wr_i && event_pending_flag_o);
endmodule : status_event_monitor

bind device_status_event_regs status_event_monitor #(.ADDR_W(ADDR_W)) status_event_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .evmem_rd_i(evmem_rd_i),
  .evmem_addr_i(evmem_addr_i), .evmem_data_o(evmem_data_o), .evmem_valid_o(evmem_valid_o),
  .master_status_wr_i(master_status_wr_i), .wdg_expire_i(wdg_expire_i),
  .event_pending_flag_o(event_pending_flag_o), .event_class_octet_o(event_class_octet_o),
  .event_id_high_o(event_id_high_o));

// ===== test/link_master_model.sv
// Purpose: link master reading event memory and writing the status octet
// Assumes: strobes one cycle, answer one cycle after the strobe
// Notes: released address and data show the inverse, never a stale copy
`timescale 1ns/1ps
module link_master_model (
  // clock and device answer
  input wire logic clk_i,
  input wire logic [7:0] evmem_data_o,
  input wire logic evmem_valid_o,
  // strobes to the device
  output logic evmem_rd_i,
  output logic [7:0] evmem_addr_i,
  output logic master_status_wr_i,
  output logic [7:0] master_status_data_i
);
  initial begin
    evmem_rd_i = 1'b0;
    evmem_addr_i = 8'hff;
    master_status_wr_i = 1'b0;
    master_status_data_i = 8'hff;
  end
  // one event memory read; q is x when no answer came
  task ev_rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    evmem_rd_i <= 1'b1;
    evmem_addr_i <= a;
    @(posedge clk_i);
    evmem_rd_i <= 1'b0;
    evmem_addr_i <= ~a;
    @(posedge clk_i);
    q = (evmem_valid_o === 1'b1) ? evmem_data_o : 8'hxx;
  endtask : ev_rd
  // one write access to the status octet
  task ms_wr(input logic [7:0] d);
    @(posedge clk_i);
    master_status_wr_i <= 1'b1;
    master_status_data_i <= d;
    @(posedge clk_i);
    master_status_wr_i <= 1'b0;
    master_status_data_i <= ~d;
    @(posedge clk_i);
  endtask : ms_wr
endmodule : link_master_model

// ===== test/test_device_status_event_regs.sv
// Purpose: self-checking bench for the status and event register group
// Assumes: wishbone answers in one cycle, link model on the far side
// Notes: expected octets come from written values, zero reset values and the zero unmapped answer
`timescale 1ns/1ps
module test_device_status_event_regs;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, wdg_expire_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000, dat_o;
  logic ack_o, evmem_rd_i, evmem_valid_o, master_status_wr_i, event_pending_flag_o, irq_o;
  logic [7:0] evmem_addr_i, evmem_data_o, master_status_data_i, event_class_octet_o, event_id_high_o, q;
  int mismatches = 0, total_checks = 0;
  device_status_event_regs device_status_event_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .evmem_rd_i(evmem_rd_i), .evmem_addr_i(evmem_addr_i), .evmem_data_o(evmem_data_o),
    .evmem_valid_o(evmem_valid_o), .master_status_wr_i(master_status_wr_i),
    .master_status_data_i(master_status_data_i), .wdg_expire_i(wdg_expire_i),
    .event_pending_flag_o(event_pending_flag_o), .event_class_octet_o(event_class_octet_o),
    .event_id_high_o(event_id_high_o), .irq_o(irq_o));
  link_master_model link_master_model_inst (.clk_i(clk_i), .evmem_data_o(evmem_data_o),
    .evmem_valid_o(evmem_valid_o), .evmem_rd_i(evmem_rd_i), .evmem_addr_i(evmem_addr_i),
    .master_status_wr_i(master_status_wr_i), .master_status_data_i(master_status_data_i));
  // free running clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    dat_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    dat_i <= ~dat_i;
  endtask : wb
  task rd(input logic [7:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(q, e);
  endtask : rd
  // watchdog expiry strobe, effect visible on return
  task expire;
    @(posedge clk_i);
    wdg_expire_i <= 1'b1;
    @(posedge clk_i);
    wdg_expire_i <= 1'b0;
    @(posedge clk_i);
  endtask : expire
  // hang guard
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 8'h28; i <= 8'h2e; i++) rd(i[7:0], 8'h00);
    for (int i = 8'h40; i <= 8'h42; i++) rd(i[7:0], 8'h00);
    for (int i = 8'h28; i <= 8'h2e; i++) wb(1'b1, i[7:0], 8'ha0 + i[7:0]);
    for (int i = 8'h28; i <= 8'h2e; i++) rd(i[7:0], (i == 8'h29) ? 8'h00 : 8'ha0 + i[7:0]);
    chk(event_class_octet_o, 8'hcd);
    chk(event_id_high_o, 8'hce);
    wb(1'b1, 8'h3f, 8'h55);
    rd(8'h3f, 8'h00);
    link_master_model_inst.ev_rd(8'h00, q);
    chk(q, 8'hcb);
    link_master_model_inst.ev_rd(8'h05, q);
    chk(q, 8'h00);
    expire();
    chk(event_pending_flag_o, 1'b0);
    rd(8'h2c, 8'hcc);
    // the earlier status read left its sticky bit; clear so irq shows the expiry alone
    wb(1'b1, 8'h41, 8'h07);
    wb(1'b1, 8'h42, 8'h07);
    chk(irq_o, 1'b0);
    wb(1'b1, 8'h40, 8'h02);
    expire();
    rd(8'h2c, 8'hca);
    chk(event_pending_flag_o, 1'b1);
    chk(irq_o, 1'b1);
    rd(8'h41, 8'h01);
    link_master_model_inst.ev_rd(8'h00, q);
    chk(q, 8'hca);
    link_master_model_inst.ms_wr(8'h33);
    chk(event_pending_flag_o, 1'b0);
    rd(8'h2c, 8'h33);
    rd(8'h41, 8'h07);
    wb(1'b1, 8'h41, 8'h07);
    rd(8'h41, 8'h00);
    chk(irq_o, 1'b0);
    wb(1'b1, 8'h42, 8'h00);
    expire();
    chk(irq_o, 1'b0);
    rd(8'h41, 8'h01);
    rd(8'h40, 8'h03);
    link_master_model_inst.ms_wr(8'h44);
    chk(event_pending_flag_o, 1'b0);
    // expiry and master write in one cycle: the set wins
    fork
      expire();
      link_master_model_inst.ms_wr(8'h55);
    join
    chk(event_pending_flag_o, 1'b1);
    rd(8'h2c, 8'hca);
    // second reset in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(event_pending_flag_o, 1'b0);
    rd(8'h2c, 8'h00);
    rd(8'h40, 8'h00);
    // a write without lane 0 enabled must not land
    sel_i <= 4'he;
    wb(1'b1, 8'h28, 8'h11);
    sel_i <= 4'hf;
    rd(8'h28, 8'h00);
    // host sets the flag by hand; visible one edge after the commit
    wb(1'b1, 8'h40, 8'h01);
    @(posedge clk_i);
    chk(event_pending_flag_o, 1'b1);
    report_and_stop();
  end
endmodule : test_device_status_event_regs
